/* src/uft_frame_timing.sv */
`timescale 1ns/1ps
module uft_frame_timing (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register access
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_hit,
  // Frame period register contents
  input wire logic [13:0] period_length_value,
  input wire logic period_change_toggle,
  // Controller state
  input wire logic run_state,
  input wire logic xfer_busy,
  // Frame boundary outputs
  output logic sof_send,
  output logic mem_wr_req,
  output logic [15:0] mem_wr_data,
  input wire logic mem_wr_done,
  output logic start_of_period_flag,
  output logic list_go,
  output logic periodic_priority
);
  uft_pkg::uft_req_t req;
  uft_pkg::uft_event_t ev;
  logic bit_tick;
  logic seq_sof, seq_wreq, seq_flag, seq_go;
  logic [15:0] seq_data;

  logic [13:0] remaining_bit_count_reg, remaining_bit_count_next;
  logic remaining_toggle_copy_reg, remaining_toggle_copy_next;
  logic [15:0] sof_counter_value_reg, sof_counter_value_next;
  logic [13:0] threshold_reg, threshold_next;
  logic run_d_reg, run_d_next;
  logic reload_pend_reg, reload_pend_next;
  logic prio_reg, prio_next;
  logic [31:0] rdata_reg, rdata_next;
  logic hit_reg, hit_next;
  logic frame_start;
  logic sof_reg, wreq_reg, flag_reg, go_reg;
  logic [15:0] wdata_reg;

  function automatic logic [15:0] inc16(input logic [15:0] v);
    return 16'(v + 16'h0001);
  endfunction

  assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

  uft_bit_tick u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .enable(run_state),
    .tick(bit_tick)
  );

  always_comb begin
    remaining_bit_count_next = remaining_bit_count_reg;
    remaining_toggle_copy_next = remaining_toggle_copy_reg;
    sof_counter_value_next = sof_counter_value_reg;
    threshold_next = threshold_reg;
    run_d_next = run_state;
    reload_pend_next = reload_pend_reg;
    prio_next = prio_reg;
    ev = '0;
    frame_start = 1'b0;
    ev.run_entry = run_state && !run_d_reg;
    if (ev.run_entry) begin
      remaining_bit_count_next = period_length_value;
      sof_counter_value_next = inc16(sof_counter_value_reg);
      remaining_toggle_copy_next = period_change_toggle;
      reload_pend_next = 1'b0;
      prio_next = 1'b0;
      frame_start = 1'b1;
    end else if (run_state && bit_tick) begin
      if (reload_pend_reg) begin
        // Period sampled only at the boundary, so new values apply next frame
        remaining_bit_count_next = period_length_value;
        sof_counter_value_next = inc16(sof_counter_value_reg);
        reload_pend_next = 1'b0;
        prio_next = 1'b0;
        frame_start = 1'b1;
      end else if (remaining_bit_count_reg != 14'h0000) begin
        remaining_bit_count_next = 14'(remaining_bit_count_reg - 14'h0001);
        if (remaining_bit_count_reg == 14'h0001) begin
          reload_pend_next = 1'b1;
          remaining_toggle_copy_next = period_change_toggle;
        end
      end else begin
        reload_pend_next = 1'b1;
        remaining_toggle_copy_next = period_change_toggle;
      end
    end else if (!run_state) begin
      reload_pend_next = 1'b0;
      prio_next = 1'b0;
    end
    ev.threshold_hit = run_state && (remaining_bit_count_reg <= threshold_reg);
    // Periodic priority only claimed once the current transaction ends
    // A frame start drops the claim; the old frame's zero count must not renew it
    if (ev.threshold_hit && !xfer_busy && !frame_start) begin
      prio_next = 1'b1;
    end
    if (req.wr) begin
      unique case (req.addr)
        uft_pkg::OFS_BIT_LEFT: begin
          remaining_bit_count_next = req.wdata[uft_pkg::REMAIN_MSB:0];
          remaining_toggle_copy_next = req.wdata[uft_pkg::TOGGLE_POS];
        end
        uft_pkg::OFS_FRAME_COUNT: begin
          // Upper bits of the count are not software visible; keep them
          sof_counter_value_next = {sof_counter_value_reg[15:14], req.wdata[uft_pkg::REMAIN_MSB:0]};
        end
        uft_pkg::OFS_PERIODIC: threshold_next = req.wdata[uft_pkg::REMAIN_MSB:0];
        default: ;
      endcase
    end
    ev.sof_pulse = frame_start;
  end

  always_comb begin
    rdata_next = 32'h00000000;
    hit_next = 1'b0;
    if (req.rd) begin
      hit_next = 1'b1;
      unique case (req.addr)
        uft_pkg::OFS_BIT_LEFT: begin
          rdata_next[uft_pkg::REMAIN_MSB:0] = remaining_bit_count_reg;
          rdata_next[uft_pkg::TOGGLE_POS] = remaining_toggle_copy_reg;
        end
        uft_pkg::OFS_FRAME_COUNT: rdata_next[uft_pkg::REMAIN_MSB:0] = sof_counter_value_reg[13:0];
        uft_pkg::OFS_PERIODIC: rdata_next[uft_pkg::REMAIN_MSB:0] = threshold_reg;
        default: hit_next = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      remaining_bit_count_reg <= uft_pkg::REMAIN_RESET;
      remaining_toggle_copy_reg <= 1'b0;
      sof_counter_value_reg <= uft_pkg::FRAME_RESET;
      threshold_reg <= uft_pkg::THRESH_RESET;
      run_d_reg <= 1'b0;
      reload_pend_reg <= 1'b0;
      prio_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      hit_reg <= 1'b0;
    end else begin
      remaining_bit_count_reg <= remaining_bit_count_next;
      remaining_toggle_copy_reg <= remaining_toggle_copy_next;
      sof_counter_value_reg <= sof_counter_value_next;
      threshold_reg <= threshold_next;
      run_d_reg <= run_d_next;
      reload_pend_reg <= reload_pend_next;
      prio_reg <= prio_next;
      rdata_reg <= rdata_next;
      hit_reg <= hit_next;
    end
  end

  uft_sof_seq u_seq (
    .clk(clk),
    .rst_n(rst_n),
    .frame_start(ev.sof_pulse),
    .frame_num(sof_counter_value_next),
    .sof_send(seq_sof),
    .mem_wr_req(seq_wreq),
    .mem_wr_data(seq_data),
    .mem_wr_done(mem_wr_done),
    .sof_flag_set(seq_flag),
    .list_go(seq_go)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sof_reg <= 1'b0;
      wreq_reg <= 1'b0;
      flag_reg <= 1'b0;
      go_reg <= 1'b0;
      wdata_reg <= 16'h0000;
    end else begin
      sof_reg <= seq_sof;
      wreq_reg <= seq_wreq && !mem_wr_done;
      flag_reg <= seq_flag;
      go_reg <= seq_go;
      wdata_reg <= seq_data;
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_hit = hit_reg;
  assign sof_send = sof_reg;
  assign mem_wr_req = wreq_reg;
  assign mem_wr_data = wdata_reg;
  assign start_of_period_flag = flag_reg;
  assign list_go = go_reg;
  assign periodic_priority = prio_reg;

  chk_reload_value: assert property (@(posedge clk) disable iff (!rst_n)
    (run_state && run_d_reg && bit_tick && reload_pend_reg && !reg_wr)
    |=> remaining_bit_count_reg == $past(period_length_value))
    else $error("counter not reloaded from period");
  chk_count_down: assert property (@(posedge clk) disable iff (!rst_n)
    (run_state && run_d_reg && bit_tick && !reload_pend_reg && remaining_bit_count_reg > 14'h0001 && !reg_wr)
    |=> remaining_bit_count_reg == 14'($past(remaining_bit_count_reg) - 14'h0001))
    else $error("counter did not decrement");
  chk_frame_incr: assert property (@(posedge clk) disable iff (!rst_n)
    (frame_start && !reg_wr) |=> sof_counter_value_reg == 16'($past(sof_counter_value_reg) + 16'h0001))
    else $error("frame number not incremented");
  chk_run_entry: assert property (@(posedge clk) disable iff (!rst_n)
    (run_state && !run_d_reg && !reg_wr) |=> remaining_bit_count_reg == $past(period_length_value))
    else $error("run entry reload missing");
  chk_toggle_copy: assert property (@(posedge clk) disable iff (!rst_n)
    (run_state && run_d_reg && bit_tick && !reload_pend_reg && remaining_bit_count_reg == 14'h0001 && !reg_wr)
    |=> remaining_toggle_copy_reg == $past(period_change_toggle))
    else $error("toggle not copied");
  chk_sof_order: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(sof_send) |=> !sof_send ##0 mem_wr_req)
    else $error("memory write not after SOF");
  chk_flag_after: assert property (@(posedge clk) disable iff (!rst_n)
    start_of_period_flag |-> $past(mem_wr_done, 2))
    else $error("flag before write completion");
  chk_tick_rate: assert property (@(posedge clk) disable iff (!rst_n)
    bit_tick |=> !bit_tick ##1 !bit_tick)
    else $error("bit tick too frequent");
  // Priority checks and the threshold register read check
  chk_prio_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (ev.threshold_hit && !xfer_busy && !frame_start) |=> periodic_priority)
    else $error("periodic priority not taken");
  chk_prio_clear: assert property (@(posedge clk) disable iff (!rst_n)
    frame_start |=> !periodic_priority)
    else $error("periodic priority kept past frame start");
  chk_busy_hold_off: assert property (@(posedge clk) disable iff (!rst_n)
    (xfer_busy && !periodic_priority) |=> !periodic_priority)
    else $error("periodic priority taken during transaction");
  chk_rd_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_rd && reg_addr == uft_pkg::OFS_PERIODIC) |=> reg_rdata[31:14] == 18'h00000 && reg_hit)
    else $error("threshold read reserved bits");

  // Register bus checks
  chk_remain_read: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_rd && reg_addr == uft_pkg::OFS_BIT_LEFT) |=> reg_hit && reg_rdata[30:14] == 17'h0
    && reg_rdata[13:0] == $past(remaining_bit_count_reg) && reg_rdata[31] == $past(remaining_toggle_copy_reg))
    else $error("remaining count read wrong");
  chk_frame_read: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_rd && reg_addr == uft_pkg::OFS_FRAME_COUNT) |=> reg_hit && reg_rdata[31:14] == 18'h0
    && reg_rdata[13:0] == 14'($past(sof_counter_value_reg)))
    else $error("frame number read wrong");
  chk_unmapped_read: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_rd && reg_addr != uft_pkg::OFS_BIT_LEFT && reg_addr != uft_pkg::OFS_FRAME_COUNT
    && reg_addr != uft_pkg::OFS_PERIODIC) |=> !reg_hit && reg_rdata == 32'h00000000)
    else $error("unmapped read answered");
  chk_remain_write: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr && reg_addr == uft_pkg::OFS_BIT_LEFT) |=> remaining_bit_count_reg == 14'($past(reg_wdata)))
    else $error("remaining count write lost");
  chk_thresh_write: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr && reg_addr == uft_pkg::OFS_PERIODIC) |=> threshold_reg == 14'($past(reg_wdata)))
    else $error("threshold write lost");

  // Boundary sequence checks
  chk_sof_width: assert property (@(posedge clk) disable iff (!rst_n)
    sof_send |=> !sof_send)
    else $error("SOF pulse too long");
  chk_req_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (mem_wr_req && !mem_wr_done) |=> mem_wr_req)
    else $error("memory write request dropped early");
  chk_wdata_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (mem_wr_req && !mem_wr_done) |=> $stable(mem_wr_data))
    else $error("memory write data moved");
  chk_flag_list: assert property (@(posedge clk) disable iff (!rst_n)
    start_of_period_flag |-> list_go)
    else $error("list fetch not with flag");
  chk_flag_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    start_of_period_flag |=> !start_of_period_flag)
    else $error("flag pulse too long");

  cov_frame: cover property (@(posedge clk) disable iff (!rst_n) frame_start);
  cov_flag: cover property (@(posedge clk) disable iff (!rst_n) start_of_period_flag);
  cov_prio: cover property (@(posedge clk) disable iff (!rst_n) $rose(periodic_priority));
  cov_busy_hold: cover property (@(posedge clk) disable iff (!rst_n) xfer_busy && ev.threshold_hit);
  cov_wrap: cover property (@(posedge clk) disable iff (!rst_n) sof_counter_value_reg == 16'hFFFF ##[1:200] frame_start);
endmodule

/* src/uft_pkg.sv */
package uft_pkg;
  // Register offsets within the operational register space
  localparam logic [7:0] OFS_BIT_LEFT = 8'h38;
  localparam logic [7:0] OFS_FRAME_COUNT = 8'h3C;
  localparam logic [7:0] OFS_PERIODIC = 8'h40;
  // Field positions
  localparam int REMAIN_MSB = 13;
  localparam int TOGGLE_POS = 31;
  localparam int SOF_FLAG_POS = 2;
  // Reset values
  localparam logic [13:0] PERIOD_RESET = 14'h2EDF;
  localparam logic [13:0] REMAIN_RESET = 14'h0000;
  localparam logic [15:0] FRAME_RESET = 16'h0000;
  localparam logic [13:0] THRESH_RESET = 14'h0000;
  // Timing: 40 MHz core, 12 Mbit/s bit rate, fractional accumulator
  localparam int CLK_HZ = 40000000;
  localparam int BIT_HZ = 12000000;
  localparam logic [6:0] ACC_STEP = 7'(BIT_HZ / 400000);
  localparam logic [6:0] ACC_WRAP = 7'(CLK_HZ / 400000);

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } uft_req_t;

  typedef struct packed {
    logic sof_pulse;
    logic run_entry;
    logic threshold_hit;
  } uft_event_t;
endpackage

/* src/uft_bit_tick.sv */
`timescale 1ns/1ps
module uft_bit_tick (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic enable,
  output logic tick
);
  logic [6:0] acc_reg;
  logic [6:0] acc_next;
  logic tick_reg;
  logic tick_next;
  logic [7:0] sum;

  always_comb begin
    sum = {1'b0, acc_reg} + {1'b0, uft_pkg::ACC_STEP};
    acc_next = acc_reg;
    tick_next = 1'b0;
    if (enable) begin
      if (sum >= {1'b0, uft_pkg::ACC_WRAP}) begin
        acc_next = 7'(sum - {1'b0, uft_pkg::ACC_WRAP});
        tick_next = 1'b1;
      end else begin
        acc_next = sum[6:0];
      end
    end else begin
      acc_next = 7'h00;
    end
  end

  // Twelve ticks per forty clocks, one pulse each
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_reg <= 7'h00;
      tick_reg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      tick_reg <= tick_next;
    end
  end
  assign tick = tick_reg;
endmodule

/* src/uft_sof_seq.sv */
`timescale 1ns/1ps
module uft_sof_seq (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Frame boundary and memory port
  input wire logic frame_start,
  input wire logic [15:0] frame_num,
  output logic sof_send,
  output logic mem_wr_req,
  output logic [15:0] mem_wr_data,
  input wire logic mem_wr_done,
  output logic sof_flag_set,
  output logic list_go
);
  typedef enum logic [1:0] {S_IDLE, S_SOF, S_WRITE, S_DONE} uft_seq_t;
  uft_seq_t st_reg, st_next;
  logic [15:0] num_reg, num_next;

  always_comb begin
    st_next = st_reg;
    num_next = num_reg;
    unique case (st_reg)
      S_IDLE: begin
        if (frame_start) begin
          st_next = S_SOF;
          num_next = frame_num;
        end
      end
      S_SOF: st_next = S_WRITE;
      S_WRITE: begin
        if (mem_wr_done) begin
          st_next = S_DONE;
        end
      end
      S_DONE: st_next = S_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= S_IDLE;
      num_reg <= 16'h0000;
    end else begin
      st_reg <= st_next;
      num_reg <= num_next;
    end
  end

  // SOF first, then memory write, then flag and list fetch
  assign sof_send = (st_reg == S_SOF);
  assign mem_wr_req = (st_reg == S_WRITE);
  assign mem_wr_data = num_reg;
  assign sof_flag_set = (st_reg == S_DONE);
  assign list_go = (st_reg == S_DONE);
endmodule

/* bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic clk, rst_n, reg_wr, reg_rd, run_state, xfer_busy, mem_wr_done, period_change_toggle;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [13:0] period_length_value;
  logic reg_hit, sof_send, mem_wr_req, start_of_period_flag, list_go, periodic_priority;
  logic [15:0] mem_wr_data;
  int mismatches, compares;

  uft_frame_timing i_dut (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .period_length_value(period_length_value), .period_change_toggle(period_change_toggle),
    .run_state(run_state), .xfer_busy(xfer_busy), .sof_send(sof_send), .mem_wr_req(mem_wr_req),
    .mem_wr_data(mem_wr_data), .mem_wr_done(mem_wr_done), .start_of_period_flag(start_of_period_flag),
    .list_go(list_go), .periodic_priority(periodic_priority));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Shared memory acknowledges each frame number write one cycle after the request
  always @(posedge clk) begin
    mem_wr_done <= mem_wr_req && !mem_wr_done && rst_n;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [31:0] d, output logic h);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
    h = reg_hit;
  endtask

  // Counts cycles until the next start-of-frame pulse
  task automatic wait_sof(output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (sof_send !== 1'b1 && n < 500);
    if (n >= 500) begin
      mismatches++;
      wrap_up();
    end
  endtask

  task automatic t_reset_regs();
    logic [31:0] d;
    logic h;
    reg_read(uft_pkg::OFS_BIT_LEFT, d, h);
    check("remaining reset", d, 32'h0);
    check("remaining hit", h, 1'b1);
    reg_read(uft_pkg::OFS_FRAME_COUNT, d, h);
    check("frame reset", d, 32'h0);
    reg_read(uft_pkg::OFS_PERIODIC, d, h);
    check("threshold reset", d, 32'h0);
    reg_read(8'h44, d, h);
    check("unmapped read", d, 32'h0);
    check("unmapped hit", h, 1'b0);
  endtask

  task automatic t_reg_access();
    logic [31:0] d;
    logic h;
    reg_write(uft_pkg::OFS_PERIODIC, 32'h00002ABC);
    reg_read(uft_pkg::OFS_PERIODIC, d, h);
    check("threshold rw", d, 32'h00002ABC);
    reg_write(uft_pkg::OFS_BIT_LEFT, 32'h00000155);
    reg_read(uft_pkg::OFS_BIT_LEFT, d, h);
    check("remaining rw", d, 32'h00000155);
    reg_write(uft_pkg::OFS_FRAME_COUNT, 32'h00003FFF);
    reg_read(uft_pkg::OFS_FRAME_COUNT, d, h);
    check("frame rw", d, 32'h00003FFF);
    reg_write(uft_pkg::OFS_PERIODIC, 32'h0000000A);
  endtask

  // Run entry reloads the counter, bumps the frame number and runs the SOF sequence
  task automatic t_run_entry();
    int n;
    @(posedge clk);
    run_state <= 1'b1;
    wait_sof(n);
    @(posedge clk);
    #1;
    check("sof width", sof_send, 1'b0);
    check("mem req", mem_wr_req, 1'b1);
    check("entry frame", mem_wr_data, 16'h4000);
    n = 0;
    while (mem_wr_done !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("done seen", n < 20, 1'b1);
    @(posedge clk);
    #1;
    check("flag early", {start_of_period_flag, list_go}, 2'b00);
    @(posedge clk);
    #1;
    check("flag set", {start_of_period_flag, list_go}, 2'b11);
    @(posedge clk);
    #1;
    check("flag width", {start_of_period_flag, list_go}, 2'b00);
  endtask

  // Period 20 gives 21 bit times, 70 clocks at 12 bits per 40 clocks
  task automatic t_frame_len();
    int n;
    logic [31:0] d;
    logic h;
    wait_sof(n);
    wait_sof(n);
    check("frame length", n, 70);
    @(posedge clk);
    #1;
    check("frame step", mem_wr_data, 16'h4002);
    reg_read(uft_pkg::OFS_FRAME_COUNT, d, h);
    check("frame low bits", d, 32'h00000002);
  endtask

  task automatic t_period_change();
    int n;
    logic [31:0] d;
    logic h;
    @(posedge clk);
    period_length_value <= 14'd29;
    period_change_toggle <= 1'b1;
    wait_sof(n);
    wait_sof(n);
    check("new length", n, 100);
    reg_read(uft_pkg::OFS_BIT_LEFT, d, h);
    check("toggle copy", d[31], 1'b1);
    check("count range", d[13:0] <= 14'd29, 1'b1);
  endtask

  task automatic t_priority();
    int n, hi;
    logic [31:0] d;
    logic h;
    @(posedge clk);
    xfer_busy <= 1'b1;
    wait_sof(n);
    hi = 0;
    for (int i = 0; i < 90; i++) begin
      @(posedge clk);
      #1;
      if (periodic_priority === 1'b1) hi++;
    end
    check("busy holds off", hi, 0);
    @(posedge clk);
    xfer_busy <= 1'b0;
    wait_sof(n);
    check("prio cleared", periodic_priority, 1'b0);
    n = 0;
    while (periodic_priority !== 1'b1 && n < 150) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("prio rises", n < 150, 1'b1);
    reg_read(uft_pkg::OFS_BIT_LEFT, d, h);
    check("prio at thresh", d[13:0] <= 14'd10, 1'b1);
  endtask

  initial begin
    rst_n = 1'b0;
    {reg_wr, reg_rd, run_state, xfer_busy, mem_wr_done} = 5'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    period_length_value = 14'd20;
    period_change_toggle = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset_regs();
    t_reg_access();
    t_run_entry();
    t_frame_len();
    t_period_change();
    t_priority();
    @(posedge clk);
    rst_n <= 1'b0;
    run_state <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset_regs();
    wrap_up();
  end
endmodule
